/* include/spief_pkg.sv */
// Purpose: Shared types and constants of the serial unit error/low-power
//          block (control, status, pin and wake bundles).
// Assumes: One byte per transfer, most significant bit first.
// Notes:   Rate codes give the master half period in system clock cycles.

`default_nettype none

package spief_pkg;

  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned HALF_W      = 7;
  localparam logic [7:0]  DATA_RST    = 8'h00;

  // Master half period per rate code {div_enable, rate[1:0]}
  localparam logic [2:0]  RATE_F4     = 3'h4;
  localparam logic [2:0]  RATE_F8     = 3'h0;
  localparam logic [2:0]  RATE_F16    = 3'h1;
  localparam logic [2:0]  RATE_F32    = 3'h6;
  localparam logic [2:0]  RATE_F64    = 3'h2;
  localparam logic [6:0]  HALF_F4     = 7'h02;
  localparam logic [6:0]  HALF_F8     = 7'h04;
  localparam logic [6:0]  HALF_F16    = 7'h08;
  localparam logic [6:0]  HALF_F32    = 7'h10;
  localparam logic [6:0]  HALF_F64    = 7'h20;
  localparam logic [6:0]  HALF_F128   = 7'h40;

  // ----------------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       serial_irq_enable;
    logic       peripheral_enable_bit;
    logic       rate_div_enable;
    logic       master_select_bit;
    logic       clock_idle_polarity;
    logic       clock_capture_phase;
    logic [1:0] rate_sel;
  } spief_ctrl_type;

  typedef struct packed {
    logic transfer_complete_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic reserved;
    logic output_disable;
    logic software_select_mgmt;
    logic software_select_level;
  } spief_stat_type;

  localparam spief_ctrl_type CTRL_RST = 8'h00;
  localparam spief_stat_type STAT_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Pin drives and wake requests
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso_oe;
  } spief_pins_type;

  typedef struct packed {
    logic irq;
    logic wait_wake;
    logic halt_wake;
  } spief_wake_type;

  localparam spief_pins_type PINS_RST = 5'h00;
  localparam spief_wake_type WAKE_RST = 3'h0;

  typedef enum logic {MST_IDLE, MST_RUN} spief_mst_state_type;

endpackage

`default_nettype wire

/* hdl/spief_core.sv */
// Purpose: Serial unit core: master engine, slave shifter on the link
//          clock, error flags, shared interrupt and low-power wake.
// Assumes: CPU strobes are one-cycle pulses on i_sys_clk; i_halt is a
//          level from the power controller on the same clock.
// Notes:   Baud generation and slave-side shifting are kept minimal.
//
// Operation
// - Polarity and phase pick one of four clock/data timings and capture edge.
// - As master, a low slave select raises a mode fault.
// - Mode fault sets its flag and interrupts when enabled.
// - Mode fault clears peripheral enable, blocking all outputs.
// - Mode fault clears master select, falling back to slave.
// - Mode fault flag clears on status read then control write.
// - While mode fault stands, enable/master writes are refused except clearing.
// - A slave never sets mode fault; an old flag may stay.
// - Byte done while transfer flag still set raises overrun.
// - After overrun the buffer keeps the first byte; later bytes dropped.
// - Overrun clears on a status register read.
// - Data write during a transfer is ignored and flags a collision.
// - Write collision never raises an interrupt.
// - Received bytes go to a CPU-synchronous buffer; no read collision.
// - WAIT has no effect; enabled events wake from WAIT.
// - HALT freezes CPU-side writes and the master engine; operation resumes after a wake-up.
// - As slave, transfer complete wakes the device from HALT.
// - Several bytes before the HALT wake is serviced raise overrun.
// - All events but write collision share one gated vector; only transfer complete exits HALT.
// - Transfer flag clears on status access then data access.

`timescale 1ns/1ns
`default_nettype none

module spief_core #(
  parameter int unsigned DATA_W = spief_pkg::DATA_W
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_resetn,
  input  wire logic                     i_link_sck,
  input  wire logic                     i_mosi,
  input  wire logic                     i_miso,
  input  wire logic                     i_ss_n,
  input  wire logic                     i_halt,
  input  wire logic                     i_int_mask,
  input  wire logic                     i_cr_wr,
  input  wire spief_pkg::spief_ctrl_type i_cr_wdata,
  input  wire logic                     i_csr_rd,
  input  wire logic                     i_csr_wr,
  input  wire spief_pkg::spief_stat_type i_csr_wdata,
  input  wire logic                     i_dr_rd,
  input  wire logic                     i_dr_wr,
  input  wire logic [DATA_W-1:0]        i_dr_wdata,
  output spief_pkg::spief_ctrl_type     o_cr,
  output spief_pkg::spief_stat_type     o_csr,
  output logic [DATA_W-1:0]             o_dr_rdata,
  output spief_pkg::spief_pins_type     o_pins,
  output logic                          o_miso,
  output spief_pkg::spief_wake_type     o_wake
);
  import spief_pkg::*;

  localparam int unsigned EDGE_W = $clog2(2 * DATA_W);
  localparam int unsigned BIT_W  = $clog2(DATA_W);
  localparam logic [EDGE_W-1:0] EDGE_LAST = EDGE_W'(2 * DATA_W - 1);
  localparam logic [BIT_W-1:0]  BIT_LAST  = BIT_W'(DATA_W - 1);

  if (DATA_W < 2 || DATA_W > 16) begin : g_check
    $error("spief_core: DATA_W must lie in 2..16");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  spief_ctrl_type      ctrl;
  spief_stat_type      stat;
  spief_pins_type      pins;
  spief_wake_type      wake;
  spief_mst_state_type mst_state;
  logic [DATA_W-1:0]   rx_buf;
  logic [DATA_W-1:0]   tx_word;
  logic [DATA_W-1:0]   m_shift;
  logic                m_samp;
  logic                m_done;
  logic                sck_lvl;
  logic [EDGE_W-1:0]   edge_cnt;
  logic [HALF_W-1:0]   div_cnt;
  logic                tc_arm;
  logic                write_collision_flag_arm;
  logic                mode_fault_flag_arm;
  logic                ss_meta;
  logic                ss_pin;
  logic                miso_meta;
  logic                miso_in;
  logic                done_meta;
  logic                done_sync;
  logic                done_seen;
  // Link domain
  logic [BIT_W-1:0]    bit_cnt;
  logic [DATA_W-1:0]   l_shift;
  logic [DATA_W-1:0]   rx_word;
  logic                done_tgl;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic                 ss_eff_n;
  logic                 is_master;
  logic                 slave_on;
  logic                 live;
  logic                 busy;
  logic                 slv_done;
  logic                 byte_done;
  logic [DATA_W-1:0]    rx_src;
  logic                 csr_access;
  logic                 tc_clr;
  logic                 write_collision_flag_set;
  logic                 write_collision_flag_clr;
  logic                 mode_fault_flag_set;
  logic                 mode_fault_flag_clr;
  logic                 mode_fault_flag_block;
  logic                 dr_wr_ok;
  logic                 mst_start;
  logic [2:0]           rate_code;
  logic [HALF_W-1:0]    half_period;
  logic                 half_hit;
  logic                 is_sample;
  logic                 evt_any;
  spief_ctrl_type       cr_write;
  spief_stat_type       next_stat;
  spief_ctrl_type       next_ctrl;
  spief_pins_type       next_pins;
  spief_wake_type       next_wake;

  // Internal slave select from pin or software level
  assign ss_eff_n  = stat.software_select_mgmt ? stat.software_select_level
                                               : ss_pin;
  assign is_master = ctrl.master_select_bit;
  assign slave_on  = ctrl.peripheral_enable_bit & ~ctrl.master_select_bit;
  // CPU strobes, fault detection and the master only act while the CPU clock is considered running
  assign live      = ~i_halt;

  // A slave counts as busy for the whole time it is selected
  assign busy = (mst_state == MST_RUN) | (slave_on & ~ss_eff_n);

  assign slv_done  = done_sync ^ done_seen;
  assign byte_done = m_done | slv_done;
  assign rx_src    = m_done ? m_shift : rx_word;

  // Status/data sequences; every hardware set wins over a clear
  assign csr_access = live & (i_csr_rd | i_csr_wr);
  assign tc_clr     = tc_arm & live & (i_dr_rd | i_dr_wr);
  assign write_collision_flag_set   = live & i_dr_wr & busy;
  assign write_collision_flag_clr   = write_collision_flag_arm & live & (i_dr_rd | i_dr_wr);
  assign mode_fault_flag_set   = live & is_master & ~ss_eff_n;
  assign mode_fault_flag_clr   = mode_fault_flag_arm & live & i_cr_wr;
  assign mode_fault_flag_block = stat.mode_fault_flag & ~mode_fault_flag_arm;

  // Data writes are held off while an unread transfer flag stands
  assign dr_wr_ok  = live & i_dr_wr & ~busy &
                     ~(stat.transfer_complete_flag & ~tc_arm);
  assign mst_start = dr_wr_ok & is_master & ctrl.peripheral_enable_bit;

  // Master baud selection
  assign rate_code   = {ctrl.rate_div_enable, ctrl.rate_sel};
  assign half_period = (rate_code == RATE_F4)  ? HALF_F4  :
                       (rate_code == RATE_F8)  ? HALF_F8  :
                       (rate_code == RATE_F16) ? HALF_F16 :
                       (rate_code == RATE_F32) ? HALF_F32 :
                       (rate_code == RATE_F64) ? HALF_F64 : HALF_F128;
  assign half_hit    = (div_cnt == half_period - 7'h01);
  // Even edges lead; phase picks whether leading edges capture
  assign is_sample   = (edge_cnt[0] == ctrl.clock_capture_phase);

  // Control write with enable/master protected during a fault
  always_comb begin
    cr_write = i_cr_wdata;
    cr_write.peripheral_enable_bit = i_cr_wdata.peripheral_enable_bit &
                                     ~mode_fault_flag_block;
    cr_write.master_select_bit     = i_cr_wdata.master_select_bit &
                                     ~mode_fault_flag_block;
  end

  // Next control image; the fault overrides any software write
  always_comb begin
    next_ctrl = ctrl;
    if (live & i_cr_wr) begin
      next_ctrl = cr_write;
    end
    if (mode_fault_flag_set) begin
      next_ctrl.peripheral_enable_bit = 1'b0;
      next_ctrl.master_select_bit     = 1'b0;
    end
  end

  // Next status image
  always_comb begin
    next_stat = stat;
    next_stat.transfer_complete_flag = byte_done |
      (stat.transfer_complete_flag & ~tc_clr);
    next_stat.overrun_flag = (byte_done & stat.transfer_complete_flag) |
      (stat.overrun_flag & ~(live & i_csr_rd));
    next_stat.write_collision_flag = write_collision_flag_set |
      (stat.write_collision_flag & ~write_collision_flag_clr);
    next_stat.mode_fault_flag = mode_fault_flag_set |
      (stat.mode_fault_flag & ~mode_fault_flag_clr);
    next_stat.reserved = 1'b0;
    if (live & i_csr_wr) begin
      next_stat.output_disable        = i_csr_wdata.output_disable;
      next_stat.software_select_mgmt  = i_csr_wdata.software_select_mgmt;
      next_stat.software_select_level = i_csr_wdata.software_select_level;
    end
  end

  // Pin drives; a cleared enable releases every output
  always_comb begin
    next_pins.sck     = ctrl.clock_idle_polarity ^ sck_lvl;
    next_pins.sck_oe  = ctrl.peripheral_enable_bit & is_master;
    next_pins.mosi    = m_shift[DATA_W-1];
    next_pins.mosi_oe = ctrl.peripheral_enable_bit & is_master &
                        ~stat.output_disable;
    next_pins.miso_oe = slave_on & ~stat.output_disable & ~ss_eff_n;
  end

  // One vector for all events; collision deliberately left out
  assign evt_any = stat.transfer_complete_flag | stat.mode_fault_flag |
                   stat.overrun_flag;
  always_comb begin
    next_wake.irq       = ctrl.serial_irq_enable & evt_any &
                          ~i_int_mask;
    next_wake.wait_wake = ctrl.serial_irq_enable & evt_any &
                          ~i_int_mask;
    next_wake.halt_wake = ctrl.serial_irq_enable &
                          stat.transfer_complete_flag & ~i_int_mask &
                          ~is_master;
  end

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  // Pins and link toggle pass two flops before CPU-side logic sees them; the link side takes i_ss_n raw
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ss_meta   <= 1'b1;
      ss_pin    <= 1'b1;
      miso_meta <= 1'b0;
      miso_in   <= 1'b0;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_seen <= 1'b0;
    end else begin
      ss_meta   <= i_ss_n;
      ss_pin    <= ss_meta;
      miso_meta <= i_miso;
      miso_in   <= miso_meta;
      done_meta <= done_tgl;
      done_sync <= done_meta;
      done_seen <= done_sync;
    end
  end

  // ----------------------------------------------------------------------
  // CPU-side registers and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= CTRL_RST;
      stat <= STAT_RST;
      pins <= PINS_RST;
      wake <= WAKE_RST;
    end else begin
      ctrl <= next_ctrl;
      stat <= next_stat;
      pins <= next_pins;
      wake <= next_wake;
    end
  end

  // Clearing sequences arm on the status access and disarm on completion
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tc_arm   <= 1'b0;
      write_collision_flag_arm <= 1'b0;
      mode_fault_flag_arm <= 1'b0;
    end else begin
      tc_arm   <= stat.transfer_complete_flag & ~tc_clr &
                  (tc_arm | csr_access);
      write_collision_flag_arm <= stat.write_collision_flag & ~write_collision_flag_clr &
                  (write_collision_flag_arm | (live & i_csr_rd));
      mode_fault_flag_arm <= stat.mode_fault_flag & ~mode_fault_flag_clr &
                  (mode_fault_flag_arm | (live & i_csr_rd));
    end
  end

  // Receive buffer only fills while no unread byte is pending
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_buf  <= DATA_RST[DATA_W-1:0];
      tx_word <= DATA_RST[DATA_W-1:0];
    end else begin
      if (byte_done & ~stat.transfer_complete_flag) begin
        rx_buf <= rx_src;
      end
      if (dr_wr_ok & ~is_master) begin
        tx_word <= i_dr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Master engine
  // ----------------------------------------------------------------------
  // Frozen in HALT; a mode fault aborts the byte and parks the clock
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mst_state <= MST_IDLE;
      m_shift   <= DATA_RST[DATA_W-1:0];
      m_samp    <= 1'b0;
      m_done    <= 1'b0;
      sck_lvl   <= 1'b0;
      edge_cnt  <= '0;
      div_cnt   <= '0;
    end else begin
      m_done <= 1'b0;
      case (mst_state)
        MST_IDLE: begin
          sck_lvl <= 1'b0;
          if (mst_start) begin
            m_shift   <= i_dr_wdata;
            edge_cnt  <= '0;
            div_cnt   <= '0;
            mst_state <= MST_RUN;
          end
        end
        MST_RUN: begin
          if (mode_fault_flag_set) begin
            mst_state <= MST_IDLE;
            sck_lvl   <= 1'b0;
          end else if (live) begin
            div_cnt <= half_hit ? '0 : div_cnt + 7'h01;
            if (half_hit) begin
              sck_lvl  <= ~sck_lvl;
              edge_cnt <= edge_cnt + 1'b1;
              if (is_sample) begin
                m_samp <= miso_in;
              end else if (edge_cnt != '0) begin
                m_shift <= {m_shift[DATA_W-2:0], m_samp};
              end
              if (edge_cnt == EDGE_LAST) begin
                if (ctrl.clock_capture_phase) begin
                  m_shift <= {m_shift[DATA_W-2:0], miso_in};
                end
                m_done    <= 1'b1;
                mst_state <= MST_IDLE;
              end
            end
          end
        end
        default: mst_state <= MST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Slave shifter on the link clock
  // ----------------------------------------------------------------------
  // Capture edge chosen by polarity and phase; config only changes while the
  // slave is deselected, so this clock inversion never switches mid-byte.
  logic link_ss_n;
  logic link_clr_n;
  logic sample_clk;
  assign sample_clk = i_link_sck ^ ctrl.clock_idle_polarity ^
                      ctrl.clock_capture_phase;
  assign link_ss_n  = stat.software_select_mgmt ?
                      stat.software_select_level : i_ss_n;
  // Deselect restarts the bit count; the link clock may be stopped then
  assign link_clr_n = i_resetn & ~link_ss_n & slave_on;

  always_ff @(posedge sample_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= (bit_cnt == BIT_LAST) ? '0 : bit_cnt + 1'b1;
    end
  end

  // Runs on in HALT so a slave byte can still wake the device
  always_ff @(posedge sample_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      l_shift  <= DATA_RST[DATA_W-1:0];
      rx_word  <= DATA_RST[DATA_W-1:0];
      done_tgl <= 1'b0;
    end else if (slave_on) begin
      if (bit_cnt == BIT_LAST) begin
        rx_word  <= {l_shift[DATA_W-2:0], i_mosi};
        l_shift  <= tx_word;
        done_tgl <= ~done_tgl;
      end else begin
        l_shift <= {l_shift[DATA_W-2:0], i_mosi};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_cr       = ctrl;
  assign o_csr      = stat;
  assign o_dr_rdata = rx_buf;
  assign o_pins     = pins;
  assign o_miso     = l_shift[DATA_W-1];
  assign o_wake     = wake;

endmodule

`default_nettype wire

/* tb/spief_core_asserts.sv */
// Purpose: Concurrent checks on the serial core CPU-side ports.
// Assumes: Only the CPU clock domain is watched here.
// Notes:   Link-side timing is judged by the bench itself.
`timescale 1ns/1ns
`default_nettype none
module spief_core_asserts (
  input wire logic                      i_sys_clk,
  input wire logic                      i_resetn,
  input wire logic                      i_ss_n,
  input wire logic                      i_halt,
  input wire logic                      i_cr_wr,
  input wire logic                      i_csr_rd,
  input wire spief_pkg::spief_ctrl_type o_cr,
  input wire spief_pkg::spief_stat_type o_csr,
  input wire spief_pkg::spief_wake_type o_wake
);
  import spief_pkg::*;
  logic rd_seen;
  // Status read seen while the fault stands; gates the refusal check
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn)
      rd_seen <= 1'b0;
    else
      rd_seen <= o_csr.mode_fault_flag & (rd_seen | (i_csr_rd & ~i_halt));
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  fault_detect_a: assert property (
    (o_cr.master_select_bit && o_cr.peripheral_enable_bit && !i_ss_n &&
     !o_csr.software_select_mgmt && !i_halt)[*3] |->
    ##[0:2] o_csr.mode_fault_flag) else $error("mode fault missed");
  fault_off_a: assert property (
    $rose(o_csr.mode_fault_flag) |-> ##[0:1]
    (!o_cr.peripheral_enable_bit && !o_cr.master_select_bit))
    else $error("fault left unit enabled");
  slave_quiet_a: assert property (
    (!o_cr.master_select_bit)[*4] |=> !$rose(o_csr.mode_fault_flag))
    else $error("slave raised mode fault");
  fault_refuse_a: assert property (
    o_csr.mode_fault_flag && i_cr_wr && !i_halt && !i_csr_rd && !rd_seen
    |=> o_csr.mode_fault_flag && !o_cr.peripheral_enable_bit &&
    !o_cr.master_select_bit) else $error("fault write not refused");
  ovr_clear_a: assert property (
    i_csr_rd && !i_halt && !o_csr.transfer_complete_flag |=>
    !o_csr.overrun_flag) else $error("overrun not cleared");
  irq_quiet_a: assert property (
    (!o_csr.transfer_complete_flag && !o_csr.overrun_flag &&
     !o_csr.mode_fault_flag)[*3] |-> !o_wake.irq)
    else $error("irq without event");
  halt_wake_a: assert property (
    (!o_csr.transfer_complete_flag)[*3] |-> !o_wake.halt_wake)
    else $error("halt wake without transfer");
  halt_freeze_a: assert property (
    i_halt[*2] |-> $stable(o_cr)) else $error("control moved in halt");
endmodule
bind spief_core spief_core_asserts spief_core_asserts_inst (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_ss_n(i_ss_n),
  .i_halt(i_halt), .i_cr_wr(i_cr_wr), .i_csr_rd(i_csr_rd),
  .o_cr(o_cr), .o_csr(o_csr), .o_wake(o_wake));
`default_nettype wire

/* tb/spief_partner.sv */
// Purpose: Behavioural far-side master and slave for the serial core.
// Assumes: Link clock period 64 ns, phase free of the CPU clock.
// Notes:   Clock stands at its idle level between frames.
`timescale 1ns/1ns
`default_nettype none
module spief_partner (
  output logic      o_sck = 1'b0,
  output logic      o_mosi = 1'b0,
  output logic      o_ss_n = 1'b1,
  output logic      o_miso = 1'b0,
  input  wire logic i_pin_sck
);
  // Reply line has no pull, so it keeps moving
  always @(posedge i_pin_sck) o_miso <= ~o_miso;
  // Idle level; only changed while the unit is disabled
  task automatic idle(input logic p);
    o_sck = p;
  endtask
  // Select level, high while a fault is cleared
  task automatic sel(input logic v);
    o_ss_n = v;
  endtask
  // One byte msb first; from the odd start offset every fifth edge falls on a CPU clock rise
  task automatic xfer(input logic [7:0] b, input logic ph, hold);
    int i;
    o_ss_n = 1'b0;
    #33;
    for (i = 7; i >= 0; i--) begin
      if (!ph)
        o_mosi = b[i];
      #32 o_sck = ~o_sck;
      if (ph)
        o_mosi = b[i];
      #32 o_sck = ~o_sck;
    end
    #32 o_mosi = ~o_mosi;
    if (!hold)
      o_ss_n = 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/spief_core_tb.sv */
// Purpose: Self-checking bench for the serial core.
// Assumes: Partner plays the far side; CPU strobes come from tasks.
// Notes:   Master rate f/4 keeps master bytes short.
`timescale 1ns/1ns
`default_nettype none
module spief_core_tb;
  import spief_pkg::*;
  logic           clk = 1'b0;
  logic           rstn = 1'b0;
  logic           halt = 1'b0;
  logic           mask = 1'b0;
  logic           cr_wr = 1'b0;
  logic           csr_rd = 1'b0;
  logic           csr_wr = 1'b0;
  logic           dr_rd = 1'b0;
  logic           dr_wr = 1'b0;
  logic [7:0]     d = 8'h00;
  logic           sck, mosi, ss_n, miso, so;
  spief_ctrl_type cr;
  spief_stat_type csr;
  spief_pins_type pins;
  spief_wake_type wake;
  logic [7:0]     rd, b;
  logic [10:0]    st;
  int             err_total = 0;
  int             checks = 0;
  int             seed = 96;
  int             cyc = 0;
  int             m;
  assign st = {wake, csr};
  spief_core spief_core_inst (
    .i_sys_clk(clk), .i_resetn(rstn), .i_link_sck(sck), .i_mosi(mosi),
    .i_miso(miso), .i_ss_n(ss_n), .i_halt(halt), .i_int_mask(mask),
    .i_cr_wr(cr_wr), .i_cr_wdata(d), .i_csr_rd(csr_rd),
    .i_csr_wr(csr_wr), .i_csr_wdata(d), .i_dr_rd(dr_rd),
    .i_dr_wr(dr_wr), .i_dr_wdata(d), .o_cr(cr), .o_csr(csr),
    .o_dr_rdata(rd), .o_pins(pins), .o_miso(so), .o_wake(wake));
  spief_partner spief_partner_inst (
    .o_sck(sck), .o_mosi(mosi), .o_ss_n(ss_n), .o_miso(miso),
    .i_pin_sck(pins.sck));
  // Control image with irq enable on and the fastest master rate
  function automatic logic [7:0] mk(input logic pe, ms, pol, pha);
    return {1'b1, pe, RATE_F4[2], ms, pol, pha, RATE_F4[1:0]};
  endfunction
  // One strobe: 0 ctrl wr, 1 status rd, 2 status wr, 3 data rd, 4 data wr
  task automatic op(input int k, input logic [7:0] v);
    @(posedge clk);
    d <= v;
    cr_wr  <= (k == 0);
    csr_rd <= (k == 1);
    csr_wr <= (k == 2);
    dr_rd  <= (k == 3);
    dr_wr  <= (k > 3);
    @(posedge clk);
    {cr_wr, csr_rd, csr_wr, dr_rd, dr_wr} <= 5'h00;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a status or wake bit, then let outputs settle
  task automatic wt(input int k);
    int n;
    for (n = 0; n < 300 && st[k] !== 1'b1; n++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic ck(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cb(input string nm, input logic e, input int k);
    ck(nm, {7'h00, e}, {7'h00, st[k]});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always #5 clk = ~clk;
  // Cut a hung run short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (m = 0; m < 4; m++) begin
      b = 8'($random(seed));
      op(0, mk(1'b0, 1'b0, m[1], m[0]));
      spief_partner_inst.idle(m[1]);
      op(0, mk(1'b1, 1'b0, m[1], m[0]));
      spief_partner_inst.xfer(b, m[0], 1'b0);
      wt(7);
      ck("rx", b, rd);
      cb("irq", 1'b1, 10);
      cb("wait wake", 1'b1, 9);
      @(posedge clk) mask <= 1'b1;
      repeat (3) @(posedge clk);
      #1 cb("masked", 1'b0, 10);
      mask <= 1'b0;
      op(1, 8'h00);
      op(3, 8'h00);
      cb("tc clr", 1'b0, 7);
    end
    $display("modes done");
    b = 8'($random(seed));
    spief_partner_inst.xfer(b, 1'b1, 1'b0);
    wt(7);
    spief_partner_inst.xfer(~b, 1'b1, 1'b0);
    wt(5);
    cb("ovr", 1'b1, 5);
    ck("kept", b, rd);
    op(1, 8'h00);
    cb("ovr clr", 1'b0, 5);
    op(3, 8'h00);
    $display("overrun done");
    spief_partner_inst.sel(1'b0);
    // Let the select pass the pin synchroniser before the write
    repeat (3) @(posedge clk);
    op(4, 8'($random(seed)));
    cb("write_collision_flag", 1'b1, 6);
    cb("no irq", 1'b0, 10);
    cb("slave mode_fault_flag", 1'b0, 4);
    op(1, 8'h00);
    op(3, 8'h00);
    cb("write_collision_flag clr", 1'b0, 6);
    spief_partner_inst.sel(1'b1);
    $display("collision done");
    op(0, mk(1'b0, 1'b0, 1'b0, 1'b0));
    spief_partner_inst.idle(1'b0);
    op(2, 8'h00);
    op(0, mk(1'b1, 1'b1, 1'b0, 1'b0));
    ck("m oe", 8'h06, {5'h00, pins.sck_oe, pins.mosi_oe, pins.miso_oe});
    op(4, b);
    op(4, ~b);
    wt(7);
    cb("m write_collision_flag", 1'b1, 6);
    op(1, 8'h00);
    op(3, 8'h00);
    spief_partner_inst.sel(1'b0);
    wt(4);
    ck("fault cr", mk(1'b0, 1'b0, 1'b0, 1'b0), cr);
    ck("fault oe", 8'h00, {5'h00, pins.sck_oe, pins.mosi_oe, pins.miso_oe});
    cb("fault irq", 1'b1, 10);
    op(0, mk(1'b1, 1'b1, 1'b0, 1'b0));
    ck("refused", mk(1'b0, 1'b0, 1'b0, 1'b0), cr);
    cb("mode_fault_flag held", 1'b1, 4);
    spief_partner_inst.sel(1'b1);
    op(1, 8'h00);
    op(0, mk(1'b1, 1'b1, 1'b0, 1'b0));
    cb("mode_fault_flag clr", 1'b0, 4);
    ck("restored", mk(1'b1, 1'b1, 1'b0, 1'b0), cr);
    $display("fault done");
    op(0, mk(1'b1, 1'b0, 1'b0, 1'b1));
    // Select by the software level this time, pin still high
    op(2, 8'h02);
    @(posedge clk) halt <= 1'b1;
    op(0, 8'h00);
    ck("frozen", mk(1'b1, 1'b0, 1'b0, 1'b1), cr);
    b = 8'($random(seed));
    spief_partner_inst.xfer(b, 1'b1, 1'b1);
    wt(8);
    cb("halt wake", 1'b1, 8);
    halt <= 1'b0;
    op(1, 8'h00);
    op(3, 8'h00);
    ck("halt rx", b, rd);
    // Refused collision write must not have reached the transmit byte
    ck("miso", 8'h00, {7'h00, so});
    spief_partner_inst.xfer(~b, 1'b1, 1'b0);
    $display("halt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
